// ### hdl/mcre_pkg.sv
// Package: constants, register map and types of the control retransmit engine
package mcre_pkg;
   // ----------------------------------------
   // Control type codes
   // ----------------------------------------
   localparam logic [5:0] CT_ENROL = 6'h01;
   localparam logic [5:0] CT_LINK = 6'h02;
   localparam logic [5:0] CT_ELEV = 6'h03;
   localparam logic [5:0] CT_SLOT = 6'h05;
   localparam logic [5:0] CT_RSV = 6'h06;
   localparam logic [5:0] CT_KEEP = 6'h07;
   localparam logic [5:0] CT_GROUP = 6'h08;
   localparam logic [5:0] CT_KEY = 6'h0A;
   localparam logic [5:0] CT_SCHED = 6'h0B;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_RETX_MIN = 8'h10;
   localparam logic [7:0] OFS_FAIL_TIME = 8'h14;
   localparam logic [7:0] OFS_REQ = 8'h18;
   localparam logic [7:0] OFS_RX = 8'h1C;
   localparam logic [7:0] OFS_CAPS = 8'h20;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_END_NODE = 0;
   localparam int CTRL_ENROLLED = 1;
   localparam int CTRL_THREE_MSG = 2;
   localparam int CTRL_SEND = 3;
   localparam int CTRL_ABORT = 4;
   localparam int CAP_NEG = 0;
   localparam int CAP_ROAM = 1;
   localparam int CAP_SPC_LO = 2;
   localparam int CAP_ROBUST = 4;
   localparam int CAP_LEGACY = 5;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_RETX = 2;
   localparam int IRQ_DUP = 3;
   localparam int IRQ_NEW = 4;
   localparam int IRQ_LATE = 5;
   localparam int IRQ_W = 6;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int RETX_MIN_US = 100;
   localparam int FAIL_TIME_US = 1000;
   localparam logic [31:0] RETX_MIN_RST = 32'(RETX_MIN_US * CLK_MHZ);
   localparam logic [31:0] FAIL_TIME_RST = 32'(FAIL_TIME_US * CLK_MHZ);
   localparam logic [31:0] BUS_ERR_RD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {MCRE_IDLE, MCRE_WAIT, MCRE_DONE, MCRE_FAILED} mcre_state_e;
endpackage

// ### hdl/mcre_timer.sv
// Down-counter timer with load, stop and one-cycle expiry pulse
module mcre_timer (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic load, // Load count and start
   input wire logic stop, // Stop without expiry
   input wire logic [31:0] count, // Cycles to expiry
   output logic running, // Timer active
   output logic expired // Expiry pulse
);
   logic [31:0] cnt_r;
   logic run_r;
   logic exp_r;
   wire zero_w = (cnt_r <= 32'h0000_0001);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 32'h0000_0000;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end else begin
         exp_r <= 1'b0;
         if (load) begin
            // A zero load still waits one cycle
            cnt_r <= (count == 32'h0000_0000) ? 32'h0000_0001 : count;
            run_r <= 1'b1;
         end else if (stop) begin
            run_r <= 1'b0;
         end else if (run_r) begin
            if (zero_w) begin
               run_r <= 1'b0;
               exp_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 32'h0000_0001;
            end
         end
      end
   end
   assign running = run_r;
   assign expired = exp_r;
endmodule

// ### hdl/mcre_engine.sv
// Control packet retransmit engine with AXI4-Lite register slave
//
// Local design decisions: the address map and register access over AXI4-Lite.
module mcre_engine (
   input wire logic aclk, // Clock, 200 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic rx_valid, // Received packet pulse
   input wire logic rx_control_indicator_bit, // Control indicator of received packet
   input wire logic [5:0] rx_control_type_field, // Control type of received packet
   input wire logic [7:0] rx_txn_id, // Transaction identifier
   input wire logic rx_is_response, // Received packet answers our request
   output logic tx_valid, // Transmit request pulse
   output logic [5:0] tx_control_type_field, // Control type to send
   output logic [7:0] tx_txn_id, // Transaction identifier to send
   output logic tx_is_reply, // Packet is a reply
   output logic [5:0] tx_enrol_flags, // Enrolment flag bits to send
   output logic fail_result, // Failure result pulse to upper layer
   output logic disconnected, // End node back in disconnected state
   output logic irq // Interrupt, active high level
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [4:0] ctrl_r;
   logic [31:0] retx_min_r;
   logic [31:0] fail_time_r;
   logic [13:0] req_r;
   logic [5:0] caps_r;
   logic [5:0] irq_stat_r;
   logic [5:0] irq_mask_r;
   logic [7:0] last_rx_id_r;
   logic [5:0] last_rx_type_r;
   logic last_rx_vld_r;
   logic [7:0] jitter_r;
   logic disc_r;
   logic tx_valid_r;
   logic [5:0] tx_type_r;
   logic [7:0] tx_id_r;
   logic tx_reply_r;
   logic fail_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic rvalid_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   mcre_pkg::mcre_state_e state_r;
   mcre_pkg::mcre_state_e state_nxt;
   // ----------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------
   wire aw_take = s_axi_awvalid && !aw_hold_r && !bvalid_r;
   wire w_take = s_axi_wvalid && !w_hold_r && !bvalid_r;
   wire aw_have = aw_hold_r || aw_take;
   wire w_have = w_hold_r || w_take;
   wire wr_fire = aw_have && w_have && !bvalid_r;
   wire [7:0] wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_r ? wdata_r : s_axi_wdata;
   wire wr_ctrl = wr_fire && wr_addr == mcre_pkg::OFS_CTRL;
   wire wr_istat = wr_fire && wr_addr == mcre_pkg::OFS_IRQ_STAT;
   wire wr_imask = wr_fire && wr_addr == mcre_pkg::OFS_IRQ_MASK;
   wire wr_retx = wr_fire && wr_addr == mcre_pkg::OFS_RETX_MIN;
   wire wr_fail = wr_fire && wr_addr == mcre_pkg::OFS_FAIL_TIME;
   wire wr_req = wr_fire && wr_addr == mcre_pkg::OFS_REQ;
   wire wr_caps = wr_fire && wr_addr == mcre_pkg::OFS_CAPS;
   wire wr_ok = wr_ctrl || wr_istat || wr_imask || wr_retx || wr_fail || wr_req || wr_caps
      || (wr_fire && (wr_addr == mcre_pkg::OFS_STATUS || wr_addr == mcre_pkg::OFS_RX));
   wire send_cmd = wr_ctrl && s_axi_wstrb[0] && wr_data[mcre_pkg::CTRL_SEND];
   wire abort_cmd = wr_ctrl && s_axi_wstrb[0] && wr_data[mcre_pkg::CTRL_ABORT];
   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready = !w_hold_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         bvalid_r <= 1'b0;
         bresp_r <= mcre_pkg::RESP_OKAY;
      end else begin
         if (aw_take && !wr_fire) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (w_take && !wr_fire) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? mcre_pkg::RESP_OKAY : mcre_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // Timers and transaction control
   // ----------------------------------------
   wire [5:0] req_type = req_r[5:0];
   wire [7:0] req_id = req_r[13:6];
   // Every covered kind, request or response, lives under one of these codes
   wire covered_w = req_type == mcre_pkg::CT_ENROL || req_type == mcre_pkg::CT_LINK
      || req_type == mcre_pkg::CT_ELEV || req_type == mcre_pkg::CT_GROUP
      || req_type == mcre_pkg::CT_KEY;
   wire rx_ctrl = rx_valid && rx_control_indicator_bit;
   wire rx_known = rx_control_type_field == mcre_pkg::CT_ENROL || rx_control_type_field == mcre_pkg::CT_LINK
      || rx_control_type_field == mcre_pkg::CT_ELEV || rx_control_type_field == mcre_pkg::CT_SLOT
      || rx_control_type_field == mcre_pkg::CT_RSV || rx_control_type_field == mcre_pkg::CT_KEEP
      || rx_control_type_field == mcre_pkg::CT_GROUP || rx_control_type_field == mcre_pkg::CT_KEY
      || rx_control_type_field == mcre_pkg::CT_SCHED;
   wire rx_match = rx_ctrl && rx_known && rx_is_response
      && rx_control_type_field == tx_type_r && rx_txn_id == tx_id_r;
   wire rx_req = rx_ctrl && rx_known && !rx_is_response;
   wire rx_dup = rx_req && last_rx_vld_r && rx_txn_id == last_rx_id_r
      && rx_control_type_field == last_rx_type_r;
   wire rx_new = rx_req && !rx_dup;
   wire waiting = state_r == mcre_pkg::MCRE_WAIT;
   wire complete = waiting && rx_match;
   // Any answer of a known control type that completes nothing, delayed copies of a finished one included
   wire rx_late = rx_ctrl && rx_known && rx_is_response && !complete;
   wire retx_exp;
   wire fail_exp;
   wire retx_run;
   wire fail_run;
   wire start_send = send_cmd && covered_w && !waiting;
   // Three-message responder arms its own timers on the new request reply
   wire resp_arm = rx_new && ctrl_r[mcre_pkg::CTRL_THREE_MSG] && !waiting;
   wire arm = start_send || resp_arm;
   wire resend = waiting && retx_exp && !fail_exp && !complete;
   wire failed = waiting && fail_exp && !complete;
   wire stop_all = complete || failed || abort_cmd;
   // Extra random-ish delay never shortens below the minimum
   wire [31:0] retx_load = retx_min_r + {24'h00_0000, jitter_r};
   mcre_timer u_retx (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(arm || resend),
      .stop(stop_all),
      .count(retx_load),
      .running(retx_run),
      .expired(retx_exp)
   );
   mcre_timer u_fail (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(arm),
      .stop(stop_all),
      .count(fail_time_r),
      .running(fail_run),
      .expired(fail_exp)
   );
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         mcre_pkg::MCRE_IDLE, mcre_pkg::MCRE_DONE, mcre_pkg::MCRE_FAILED: begin
            if (arm) begin
               state_nxt = mcre_pkg::MCRE_WAIT;
            end
         end
         mcre_pkg::MCRE_WAIT: begin
            if (complete || abort_cmd) begin
               state_nxt = mcre_pkg::MCRE_DONE;
            end else if (failed) begin
               state_nxt = mcre_pkg::MCRE_FAILED;
            end
         end
         default: state_nxt = mcre_pkg::MCRE_IDLE;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= mcre_pkg::MCRE_IDLE;
         jitter_r <= 8'h01;
         disc_r <= 1'b1;
         fail_r <= 1'b0;
         last_rx_vld_r <= 1'b0;
         last_rx_id_r <= 8'h00;
         last_rx_type_r <= 6'h00;
      end else begin
         state_r <= state_nxt;
         jitter_r <= {jitter_r[6:0], jitter_r[7] ^ jitter_r[5] ^ jitter_r[4] ^ jitter_r[3]};
         fail_r <= failed;
         if (failed && ctrl_r[mcre_pkg::CTRL_END_NODE]) begin
            disc_r <= 1'b1;
         end else if (complete && tx_type_r == mcre_pkg::CT_ENROL) begin
            disc_r <= 1'b0;
         end
         if (rx_new) begin
            last_rx_vld_r <= 1'b1;
            last_rx_id_r <= rx_txn_id;
            last_rx_type_r <= rx_control_type_field;
         end
      end
   end
   // ----------------------------------------
   // Transmit request
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_valid_r <= 1'b0;
         tx_type_r <= 6'h00;
         tx_id_r <= 8'h00;
         tx_reply_r <= 1'b0;
      end else begin
         tx_valid_r <= 1'b0;
         if (start_send) begin
            tx_valid_r <= 1'b1;
            tx_type_r <= req_type;
            tx_id_r <= req_id;
            tx_reply_r <= 1'b0;
         end else if (rx_req) begin
            // Repeat and new request both get a reply
            tx_valid_r <= 1'b1;
            tx_type_r <= rx_control_type_field;
            tx_id_r <= rx_txn_id;
            tx_reply_r <= 1'b1;
         end else if (resend) begin
            tx_valid_r <= 1'b1;
         end
      end
   end
   assign tx_valid = tx_valid_r;
   assign tx_control_type_field = tx_type_r;
   assign tx_txn_id = tx_id_r;
   assign tx_is_reply = tx_reply_r;
   // Roaming only makes sense when already enrolled
   assign tx_enrol_flags = {caps_r[mcre_pkg::CAP_LEGACY],
      caps_r[mcre_pkg::CAP_ROBUST],
      caps_r[mcre_pkg::CAP_SPC_LO +: 2],
      caps_r[mcre_pkg::CAP_ROAM] && ctrl_r[mcre_pkg::CTRL_ENROLLED],
      caps_r[mcre_pkg::CAP_NEG]};
   assign fail_result = fail_r;
   assign disconnected = disc_r;
   // ----------------------------------------
   // Configuration and interrupt registers
   // ----------------------------------------
   wire [5:0] ev_w = {rx_late, rx_new, rx_dup, resend, failed, complete};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= 5'h00;
         retx_min_r <= mcre_pkg::RETX_MIN_RST;
         fail_time_r <= mcre_pkg::FAIL_TIME_RST;
         req_r <= 14'h0000;
         caps_r <= 6'h00;
         irq_mask_r <= 6'h00;
         irq_stat_r <= 6'h00;
      end else begin
         if (wr_ctrl && s_axi_wstrb[0]) begin
            ctrl_r <= {2'b00, wr_data[2:0]};
         end
         if (wr_retx) begin
            retx_min_r <= wr_data;
         end
         if (wr_fail) begin
            fail_time_r <= wr_data;
         end
         if (wr_req) begin
            req_r <= wr_data[13:0];
         end
         if (wr_caps) begin
            caps_r <= wr_data[5:0];
         end
         if (wr_imask) begin
            irq_mask_r <= wr_data[5:0];
         end
         // Set wins over a write-one clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~(wr_istat ? wr_data[5:0] : 6'h00)) | ev_w;
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);
   // ----------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------
   wire ar_take = s_axi_arvalid && !rvalid_r;
   wire [31:0] status_w = {24'h00_0000, fail_run, retx_run, disc_r, 3'b000, state_r};
   wire [31:0] rx_w = {16'h0000, last_rx_vld_r, 1'b0, last_rx_type_r, last_rx_id_r};
   always_comb begin
      case (s_axi_araddr)
         mcre_pkg::OFS_CTRL: rdata_r = {27'h000_0000, ctrl_r};
         mcre_pkg::OFS_STATUS: rdata_r = status_w;
         mcre_pkg::OFS_IRQ_STAT: rdata_r = {26'h000_0000, irq_stat_r};
         mcre_pkg::OFS_IRQ_MASK: rdata_r = {26'h000_0000, irq_mask_r};
         mcre_pkg::OFS_RETX_MIN: rdata_r = retx_min_r;
         mcre_pkg::OFS_FAIL_TIME: rdata_r = fail_time_r;
         mcre_pkg::OFS_REQ: rdata_r = {18'h0_0000, req_r};
         mcre_pkg::OFS_RX: rdata_r = rx_w;
         mcre_pkg::OFS_CAPS: rdata_r = {26'h000_0000, caps_r};
         default: rdata_r = mcre_pkg::BUS_ERR_RD;
      endcase
   end
   wire rd_ok = s_axi_araddr <= mcre_pkg::OFS_CAPS && s_axi_araddr[1:0] == 2'b00;
   logic [31:0] rd_q_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rd_q_r <= 32'h0000_0000;
         rresp_r <= mcre_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rd_q_r <= rdata_r;
         rresp_r <= rd_ok ? mcre_pkg::RESP_OKAY : mcre_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rd_q_r;
   assign s_axi_rresp = rresp_r;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   done_stops_timers_a: assert property (complete |=> !retx_run && !fail_run)
      else $error("timers still running after completion");
   resend_on_expiry_a: assert property (resend |=> tx_valid && $stable(tx_control_type_field) && $stable(tx_txn_id))
      else $error("no resend after retransmit expiry");
   fail_reports_a: assert property (failed |=> fail_result ##1 !fail_result)
      else $error("failure result not pulsed");
   end_node_disc_a: assert property (failed && ctrl_r[mcre_pkg::CTRL_END_NODE] |=> disconnected)
      else $error("end node not disconnected on failure");
   dup_reply_only_a: assert property (rx_dup |=> tx_valid && tx_is_reply && $stable(last_rx_id_r))
      else $error("repeat not answered by reply alone");
   new_reply_a: assert property (rx_new |=> tx_valid && tx_is_reply && last_rx_id_r == $past(rx_txn_id))
      else $error("new request not processed");
   late_ignored_a: assert property (rx_late && !waiting |=> state_r != mcre_pkg::MCRE_WAIT || $past(arm))
      else $error("late response started a transaction");
   arm_loads_a: assert property (arm |=> retx_run && fail_run)
      else $error("timers not started on send");
   non_ctrl_ignored_a: assert property (rx_valid && !rx_control_indicator_bit && !start_send && !resend |=> !tx_valid)
      else $error("non-control packet handled");
   cover_done_c: cover property (start_send ##[1:1000] complete);
   cover_resend_c: cover property (resend);
   cover_fail_c: cover property (failed);
   cover_dup_c: cover property (rx_dup);
endmodule

// ### verification/mcre_peer_model.sv
// Peer node model: answers engine requests and injects requests of its own
module mcre_peer_model (
   input wire logic aclk, // Clock
   input wire logic tx_valid, // Packet from engine
   input wire logic [5:0] tx_control_type_field, // Its type
   input wire logic [7:0] tx_txn_id, // Its id
   input wire logic tx_is_reply, // Engine reply flag
   output logic rx_valid = 1'b0, // Packet to engine
   output logic rx_control_indicator_bit = 1'b0, // Control flag
   output logic [5:0] rx_control_type_field = 6'h00, // Type
   output logic [7:0] rx_txn_id = 8'h00, // Id
   output logic rx_is_response = 1'b0 // Answer flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] q [$];
   int drop = 0, seen = 0, delay = 0, dup = 0, wt = 0;
   // Loss, delay and duplicate knobs so the engine meets a hostile link
   task automatic cfg(input int d, input int dl, input int du);
      drop = d;
      delay = dl;
      dup = du;
      seen = 0;
   endtask
   task automatic put(input logic [15:0] p);
      q.push_back(p);
   endtask
   always @(posedge aclk) begin
      if (tx_valid === 1'b1 && tx_is_reply === 1'b0) begin
         if (seen < drop) seen++;
         else begin
            repeat (dup + 1) q.push_back({2'h3, tx_control_type_field, tx_txn_id});
            wt = delay;
         end
      end
      if (wt == 0 && q.size() > 0) begin
         {rx_control_indicator_bit, rx_is_response, rx_control_type_field, rx_txn_id} <= q.pop_front();
         rx_valid <= 1'b1;
      end else begin
         // Idle qualifiers keep moving, a stale copy must never look valid
         {rx_control_indicator_bit, rx_is_response, rx_control_type_field, rx_txn_id} <=
            ~{rx_control_indicator_bit, rx_is_response, rx_control_type_field, rx_txn_id};
         rx_valid <= 1'b0;
         if (wt > 0) wt--;
      end
   end
endmodule

// ### verification/mcre_engine_tb.sv
// Self-checking bench of the control retransmit engine
module mcre_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_txn_id, tx_txn_id;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr_v;
   logic s_axi_rvalid, rx_valid, rx_control_indicator_bit, rx_is_response, tx_valid, tx_is_reply;
   logic fail_result, disconnected, irq;
   logic [5:0] rx_control_type_field, tx_control_type_field, tx_enrol_flags, last_t;
   int n_errors = 0, cmp_count = 0, cyc = 0, tx_n = 0, rep_n = 0, n0, t;
   logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h44};
   logic [31:0] rv [7] = '{32'h0, 32'h20, 32'h0, 32'h0, 32'h4E20, 32'h30D40, 32'h0};
   logic [1:0] rs [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
   logic [5:0] codes [9] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0A, 6'h0B};
   always #2.5 aclk = ~aclk;
   mcre_engine mcre_engine_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rx_valid, .rx_control_indicator_bit, .rx_control_type_field, .rx_txn_id, .rx_is_response, .tx_valid,
      .tx_control_type_field, .tx_txn_id, .tx_is_reply, .tx_enrol_flags, .fail_result, .disconnected, .irq);
   mcre_peer_model mcre_peer_model_inst (.aclk, .tx_valid, .tx_control_type_field, .tx_txn_id, .tx_is_reply,
      .rx_valid, .rx_control_indicator_bit, .rx_control_type_field, .rx_txn_id, .rx_is_response);
   always @(posedge aclk) begin
      cyc++;
      if (tx_valid === 1'b1) begin
         tx_n++;
         rep_n += (tx_is_reply === 1'b1);
         last_t = tx_control_type_field;
      end
      if (cyc == 30000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd_v = s_axi_rdata;
      rr_v = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      chk(disconnected, 32'h1);
      for (int i = 0; i < 7; i++) begin
         rd(ra[i]);
         chk({rr_v, rd_v}, {rs[i], rv[i]});
      end
      $display("test reset done");
      wr(8'h10, 32'h14);
      wr(8'h14, 32'h3E8);
      wr(8'h0C, 32'h3F);
      wr(8'h20, 32'h3F);
      wr(8'h00, 32'h1);
      chk(tx_enrol_flags, 6'h3D);
      wr(8'h00, 32'h3);
      chk(tx_enrol_flags, 6'h3F);
      wr(8'h20, 32'h04);
      chk(tx_enrol_flags, 6'h04);
      $display("test caps done");
      // Two lost answers, a slow third and a late duplicate
      mcre_peer_model_inst.cfg(2, 3, 1);
      wr(8'h18, 32'h141);
      n0 = tx_n;
      wr(8'h00, 32'h9);
      for (t = 0; t < 2000 && disconnected !== 1'b0; t++) @(posedge aclk);
      repeat (20) @(posedge aclk);
      chk(tx_n - n0, 32'h3);
      chk({tx_control_type_field, tx_txn_id}, {6'h01, 8'h05});
      rd(8'h04);
      chk(rd_v, 32'h02);
      rd(8'h08);
      chk(rd_v, 32'h25);
      wr(8'h08, 32'h3F);
      chk(irq, 32'h0);
      $display("test retransmit done");
      mcre_peer_model_inst.cfg(255, 0, 0);
      wr(8'h14, 32'h7D0);
      wr(8'h18, 32'h182);
      n0 = tx_n;
      wr(8'h00, 32'h9);
      for (t = 0; t < 3000 && fail_result !== 1'b1; t++) @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk(disconnected, 32'h1);
      chk(tx_n - n0 > 1, 32'h1);
      rd(8'h04);
      chk(rd_v, 32'h23);
      wr(8'h08, 32'h3F);
      $display("test failure done");
      for (int i = 0; i < 10; i++) begin
         n0 = rep_n;
         // Last row repeats the one before it, so it must count as a duplicate
         mcre_peer_model_inst.put({2'h2, codes[i - i / 9], 8'(i - i / 9)});
         for (t = 0; t < 50 && rep_n == n0; t++) @(posedge aclk);
         chk({26'(rep_n - n0), last_t}, {26'h1, codes[i - i / 9]});
      end
      mcre_peer_model_inst.put({2'h0, 6'h01, 8'h55});
      mcre_peer_model_inst.put({2'h2, 6'h04, 8'h56});
      repeat (10) @(posedge aclk);
      chk(rep_n - n0, 32'h1);
      rd(8'h08);
      chk(rd_v, 32'h18);
      wr(8'h0C, 32'h0);
      chk(irq, 32'h0);
      wr(8'h0C, 32'h8);
      chk(irq, 32'h1);
      wr(8'h08, 32'h8);
      chk(irq, 32'h0);
      $display("test responder done");
      // Three-message responder retries its reply until the third message lands
      wr(8'h00, 32'h4);
      n0 = rep_n;
      mcre_peer_model_inst.put({2'h2, 6'h03, 8'h21});
      for (t = 0; t < 600 && rep_n - n0 < 2; t++) @(posedge aclk);
      chk(rep_n - n0, 32'h2);
      mcre_peer_model_inst.put({2'h3, 6'h03, 8'h21});
      repeat (5) @(posedge aclk);
      rd(8'h04);
      chk(rd_v, 32'h22);
      $display("test three-message done");
      report_and_stop();
   end
endmodule
